// ==== include/crk_pkg.sv ====
package crk_pkg;

  // Register counts and widths.
  localparam int CRK_GR_COUNT = 8;
  localparam int CRK_FR_COUNT = 2;
  localparam int CRK_BR_COUNT = 4;
  localparam int CRK_GR_SEL_W = 3;
  localparam int CRK_BR_SEL_W = 2;

  // Base register indices.
  localparam logic [1:0] CRK_BR_PROC = 2'h0;
  localparam logic [1:0] CRK_BR_STACK = 2'h1;
  localparam logic [1:0] CRK_BR_LINK = 2'h2;
  localparam logic [1:0] CRK_BR_TEMP = 2'h3;

  // Bit 1 of the architecture is the most significant bit, so bit n sits at index width-n.
  localparam int CRK_KEY_CARRY = 15;
  localparam int CRK_KEY_LINK = 13;
  localparam int CRK_KEY_MODE_HI = 12;
  localparam int CRK_KEY_MODE_LO = 10;
  localparam int CRK_KEY_FP_EXC = 9;
  localparam int CRK_KEY_INT_EXC = 8;
  localparam int CRK_KEY_NEG = 7;
  localparam int CRK_KEY_ZERO = 6;
  localparam int CRK_KEY_DEC_EXC = 5;
  localparam int CRK_KEY_IN_DISP = 1;
  localparam int CRK_KEY_SAVE_DONE = 0;

  // Bits an instruction may write, and bits owned by the process exchange.
  localparam logic [15:0] CRK_KEYS_WR_MASK = 16'hBFE0;
  localparam logic [15:0] CRK_KEYS_PXC_MASK = 16'h0003;
  localparam logic [15:0] CRK_KEYS_RST = 16'h0000;

  // Base register layout.
  localparam int CRK_BR_ZERO_HI = 31;
  localparam int CRK_BR_RING_HI = 30;
  localparam int CRK_BR_RING_LO = 29;
  localparam int CRK_BR_ZERO_LO = 28;
  localparam int CRK_BR_SEG_HI = 27;
  localparam int CRK_BR_SEG_LO = 16;
  localparam int CRK_BR_WORD_HI = 15;
  localparam int CRK_BR_WORD_LO = 0;

  localparam logic [31:0] CRK_WORD_RST = 32'h0000_0000;
  localparam logic [63:0] CRK_DWORD_RST = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    CRK_EXC_FLOAT = 2'b00,
    CRK_EXC_INTEGER = 2'b01,
    CRK_EXC_DECIMAL = 2'b10
  } crk_exc_kind_type;

  typedef struct packed {
    logic en;
    logic [2:0] sel;
    logic [31:0] data;
  } crk_gr_wr_type;

  typedef struct packed {
    logic valid;
    logic [31:0] result;
    logic sign_ext;
    logic carry_valid;
    logic carry_out;
  } crk_alu_res_type;

  typedef struct packed {
    logic valid;
    crk_exc_kind_type kind;
  } crk_exc_type;

endpackage : crk_pkg

// ==== core/crk_regset.sv ====
`timescale 1ns/1ps

// Summary of operation
// - Eight 32-bit general registers, selected by number zero through seven.
// - Only general registers one to seven supply an index; register zero gives none.
// - Any general register serves as accumulator for memory and register operations.
// - Two 64-bit floating registers, zero and one, for single or double precision.
// - Floating and field registers share storage; writing one changes the other.
// - Two 64-bit field registers, zero and one, told apart only by instruction.
// - Base registers keep bits 1 and 4 zero, with ring, segment and word fields.
// - The 16-bit keys are loaded by status-load and accumulator transfer, read back.
// - Keys bit 7 clear makes float exceptions fault; set only sets carry/error.
// - Keys bit 8 clear makes integer exceptions set carry/error; set faults.
// - Keys bit 11 clear makes decimal exceptions set carry/error; set faults.
// - Keys bit 9 holds the negative code, bit 10 the zero-result code.
// - Keys bit 15, in-dispatcher, changes only during a process exchange.
// - Keys bit 16, save-done, is set or cleared only by process exchange.
// - A crash copies the current return pointer into scratch register seven.
// - An interrupt keeps the return pointer in its own scratch register.
// - An interrupt keeps the keys in a scratch register for the return.
// - After a halt, a scratch pointer locates the register save area.
// - A machine check trap records the real memory address in diagnostics.
// - Zero code means truncated result is zero; negative follows extended sign.
module crk_regset
  import crk_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire crk_gr_wr_type gr_wr,
  input wire logic [2:0] gr_rd_sel,
  output logic [31:0] gr_rd_data,
  input wire logic [2:0] idx_sel,
  output logic [31:0] idx_data,
  output logic idx_used,
  input wire logic fr_wr_en,
  input wire logic fr_wr_sel,
  input wire logic fr_wr_single,
  input wire logic [63:0] fr_wr_data,
  input wire logic fld_addr_wr_en,
  input wire logic fld_len_wr_en,
  input wire logic fld_wr_sel,
  input wire logic [31:0] fld_wr_data,
  input wire logic fr_rd_sel,
  output logic [63:0] fr_rd_data,
  output logic [31:0] field_address_register,
  output logic [31:0] field_length_register,
  input wire logic base_wr_en,
  input wire logic [1:0] base_wr_sel,
  input wire logic [31:0] base_wr_data,
  input wire logic [1:0] base_rd_sel,
  output logic [31:0] base_rd_data,
  output logic [1:0] base_ring,
  output logic [11:0] segment_number,
  output logic [15:0] word_number,
  input wire logic load_status_word_instr,
  input wire logic accum_to_keys_instr,
  input wire logic [15:0] keys_wr_data,
  input wire crk_alu_res_type alu_res,
  input wire crk_exc_type exc,
  input wire logic pxc_en,
  input wire logic pxc_in_disp,
  input wire logic pxc_save_done,
  output logic [15:0] keys_to_accum_instr,
  output logic [2:0] addr_mode,
  output logic negative_code_flag,
  output logic zero_result_flag,
  output logic decimal_fault_enable,
  output logic fault_take,
  input wire logic crash_evt,
  input wire logic intr_evt,
  input wire logic intr_return,
  input wire logic halt_evt,
  input wire logic check_trap_evt,
  input wire logic [31:0] cur_return_ptr,
  input wire logic [31:0] halt_area_addr,
  input wire logic [31:0] check_rma,
  output logic [31:0] crash_return_save,
  output logic [31:0] interrupt_return_pointer,
  output logic [15:0] interrupt_return_keys,
  output logic [31:0] halt_save_area_pointer,
  output logic [31:0] check_trap_address
);

  logic [31:0] gr_r [CRK_GR_COUNT];
  logic [63:0] fr_r [CRK_FR_COUNT];
  logic [31:0] base_r [CRK_BR_COUNT];
  logic [15:0] keys_r;
  logic [15:0] keys_nxt;
  logic exc_fault;
  logic exc_set_carry;

  // General registers: one write port for every arithmetic, logical and load result.
  genvar gi;
  generate
    for (gi = 0; gi < CRK_GR_COUNT; gi = gi + 1) begin : g_gr
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          gr_r[gi] <= CRK_WORD_RST;
        end else if (gr_wr.en && (gr_wr.sel == 3'(gi))) begin
          gr_r[gi] <= gr_wr.data;
        end
      end
    end
  endgenerate

  // A write and a read of the same register in one cycle return the old value.
  // Forwarding was left out because the instruction path already orders them.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gr_rd_data <= CRK_WORD_RST;
    end else begin
      gr_rd_data <= gr_r[gr_rd_sel];
    end
  end

  // A select of zero means no index, so address formation adds nothing.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idx_data <= CRK_WORD_RST;
      idx_used <= 1'b0;
    end else if (idx_sel == 3'h0) begin
      idx_data <= CRK_WORD_RST;
      idx_used <= 1'b0;
    end else begin
      idx_data <= gr_r[idx_sel];
      idx_used <= 1'b1;
    end
  end

  // One storage array serves both floating and field views. The field address
  // is the high word and the length the low word, so a double floating load overwrites
  // both and a single one only the address; software must save field state before using floating registers.
  genvar fi;
  generate
    for (fi = 0; fi < CRK_FR_COUNT; fi = fi + 1) begin : g_fr
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          fr_r[fi] <= CRK_DWORD_RST;
        end else if (fr_wr_en && (fr_wr_sel == 1'(fi))) begin
          if (fr_wr_single) begin
            fr_r[fi][63:32] <= fr_wr_data[63:32];
          end else begin
            fr_r[fi] <= fr_wr_data;
          end
        end else if (fld_addr_wr_en && (fld_wr_sel == 1'(fi))) begin
          fr_r[fi][63:32] <= fld_wr_data;
        end else if (fld_len_wr_en && (fld_wr_sel == 1'(fi))) begin
          fr_r[fi][31:0] <= fld_wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fr_rd_data <= CRK_DWORD_RST;
    end else begin
      fr_rd_data <= fr_r[fr_rd_sel];
    end
  end

  // The field view reads the same entry as the floating view; there is no second select.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      field_address_register <= CRK_WORD_RST;
      field_length_register <= CRK_WORD_RST;
    end else begin
      field_address_register <= fr_r[fr_rd_sel][63:32];
      field_length_register <= fr_r[fr_rd_sel][31:0];
    end
  end

  // Base registers force their two zero bits on every write.
  genvar bi;
  generate
    for (bi = 0; bi < CRK_BR_COUNT; bi = bi + 1) begin : g_br
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          base_r[bi] <= CRK_WORD_RST;
        end else if (base_wr_en && (base_wr_sel == 2'(bi))) begin
          base_r[bi] <= base_wr_data;
          base_r[bi][CRK_BR_ZERO_HI] <= 1'b0;
          base_r[bi][CRK_BR_ZERO_LO] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      base_rd_data <= CRK_WORD_RST;
    end else begin
      base_rd_data <= base_r[base_rd_sel];
    end
  end

  // Field outputs spare the address path from slicing the whole word itself.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      base_ring <= 2'h0;
      segment_number <= 12'h000;
      word_number <= 16'h0000;
    end else begin
      base_ring <= base_r[base_rd_sel][CRK_BR_RING_HI:CRK_BR_RING_LO];
      segment_number <= base_r[base_rd_sel][CRK_BR_SEG_HI:CRK_BR_SEG_LO];
      word_number <= base_r[base_rd_sel][CRK_BR_WORD_HI:CRK_BR_WORD_LO];
    end
  end

  // Exception routing against the enables held in the keys.
  always_comb begin
    exc_fault = 1'b0;
    exc_set_carry = 1'b0;
    if (exc.valid) begin
      case (exc.kind)
        CRK_EXC_FLOAT: begin
          exc_fault = ~keys_r[CRK_KEY_FP_EXC];
          exc_set_carry = keys_r[CRK_KEY_FP_EXC];
        end
        CRK_EXC_INTEGER: begin
          exc_fault = keys_r[CRK_KEY_INT_EXC];
          exc_set_carry = ~keys_r[CRK_KEY_INT_EXC];
        end
        CRK_EXC_DECIMAL: begin
          exc_fault = keys_r[CRK_KEY_DEC_EXC];
          exc_set_carry = ~keys_r[CRK_KEY_DEC_EXC];
        end
        default: begin
          exc_fault = 1'b0;
          exc_set_carry = 1'b0;
        end
      endcase
    end
  end

  // Keys update. A whole-word load wins over condition codes and exceptions in
  // the same cycle, because the load is the later instruction's intent; the
  // dispatcher pair is owned by the process exchange alone.
  always_comb begin
    keys_nxt = keys_r;
    if (intr_return) begin
      keys_nxt = (interrupt_return_keys & CRK_KEYS_WR_MASK) | (keys_r & CRK_KEYS_PXC_MASK);
    end else if (load_status_word_instr || accum_to_keys_instr) begin
      keys_nxt = (keys_wr_data & CRK_KEYS_WR_MASK) | (keys_r & CRK_KEYS_PXC_MASK);
    end else begin
      if (alu_res.valid) begin
        keys_nxt[CRK_KEY_ZERO] = (alu_res.result == CRK_WORD_RST);
        keys_nxt[CRK_KEY_NEG] = alu_res.sign_ext;
        if (alu_res.carry_valid) begin
          keys_nxt[CRK_KEY_LINK] = alu_res.carry_out;
        end
      end
      if (exc_set_carry) begin
        keys_nxt[CRK_KEY_CARRY] = 1'b1;
      end
    end
    if (pxc_en) begin
      keys_nxt[CRK_KEY_IN_DISP] = pxc_in_disp;
      keys_nxt[CRK_KEY_SAVE_DONE] = pxc_save_done;
    end
    keys_nxt = keys_nxt & (CRK_KEYS_WR_MASK | CRK_KEYS_PXC_MASK);
  end

  // The keys change every cycle from the next-value logic, so an idle cycle
  // simply rewrites the same word.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      keys_r <= CRK_KEYS_RST;
    end else begin
      keys_r <= keys_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      keys_to_accum_instr <= CRK_KEYS_RST;
    end else begin
      keys_to_accum_instr <= keys_nxt;
    end
  end

  // Field copies are taken from the next value so they never lag the keys word.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_mode <= 3'h0;
      negative_code_flag <= 1'b0;
      zero_result_flag <= 1'b0;
      decimal_fault_enable <= 1'b0;
    end else begin
      addr_mode <= keys_nxt[CRK_KEY_MODE_HI:CRK_KEY_MODE_LO];
      negative_code_flag <= keys_nxt[CRK_KEY_NEG];
      zero_result_flag <= keys_nxt[CRK_KEY_ZERO];
      decimal_fault_enable <= keys_nxt[CRK_KEY_DEC_EXC];
    end
  end

  // The fault decision uses the enables as they stood before the exception,
  // so a keys load in the same cycle cannot change its outcome.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fault_take <= 1'b0;
    end else begin
      fault_take <= exc_fault;
    end
  end

  // Scratch saves made by microcode on crash, interrupt, halt and check trap.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      crash_return_save <= CRK_WORD_RST;
    end else if (crash_evt) begin
      crash_return_save <= cur_return_ptr;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      interrupt_return_pointer <= CRK_WORD_RST;
      interrupt_return_keys <= CRK_KEYS_RST;
    end else if (intr_evt) begin
      interrupt_return_pointer <= cur_return_ptr;
      interrupt_return_keys <= keys_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      halt_save_area_pointer <= CRK_WORD_RST;
    end else if (halt_evt) begin
      halt_save_area_pointer <= halt_area_addr;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      check_trap_address <= CRK_WORD_RST;
    end else if (check_trap_evt) begin
      check_trap_address <= check_rma;
    end
  end

endmodule : crk_regset

// ==== testbench/crk_regset_chk.sv ====
`timescale 1ns/1ps
module crk_regset_chk
  import crk_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] idx_sel,
  input wire logic [31:0] idx_data,
  input wire logic idx_used,
  input wire logic [15:0] keys_to_accum_instr,
  input wire logic [15:0] keys_wr_data,
  input wire logic load_status_word_instr,
  input wire logic accum_to_keys_instr,
  input wire logic intr_return,
  input wire crk_exc_type exc,
  input wire logic fault_take,
  input wire crk_alu_res_type alu_res,
  input wire logic zero_result_flag,
  input wire logic negative_code_flag,
  input wire logic pxc_en,
  input wire logic crash_evt,
  input wire logic intr_evt,
  input wire logic [31:0] cur_return_ptr,
  input wire logic [31:0] crash_return_save,
  input wire logic [31:0] interrupt_return_pointer,
  input wire logic [15:0] interrupt_return_keys,
  input wire logic [31:0] base_rd_data
);
  logic fault_exp;
  logic key_ld;
  assign key_ld = load_status_word_instr | accum_to_keys_instr | intr_return;
  // The enables are judged as they stood when the exception arrived, not after.
  always_comb begin
    case (exc.kind)
      CRK_EXC_FLOAT: fault_exp = exc.valid & ~keys_to_accum_instr[CRK_KEY_FP_EXC];
      CRK_EXC_INTEGER: fault_exp = exc.valid & keys_to_accum_instr[CRK_KEY_INT_EXC];
      CRK_EXC_DECIMAL: fault_exp = exc.valid & keys_to_accum_instr[CRK_KEY_DEC_EXC];
      default: fault_exp = 1'b0;
    endcase
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  idx_zero_a: assert property (idx_sel == 3'h0 |=> idx_data == 32'h0000_0000 && !idx_used)
    else $error("index zero gave a value");
  keys_rsvd_a: assert property (keys_to_accum_instr[14] == 1'b0 && keys_to_accum_instr[4:2] == 3'h0)
    else $error("reserved keys bit set");
  disp_bits_a: assert property (!pxc_en |=> $stable(keys_to_accum_instr[1:0]))
    else $error("dispatcher bits moved outside exchange");
  fault_map_a: assert property (1'b1 |=> fault_take == $past(fault_exp))
    else $error("fault decision wrong");
  carry_set_a: assert property (exc.valid && !fault_exp && !key_ld |=> keys_to_accum_instr[CRK_KEY_CARRY])
    else $error("carry not set by exception");
  key_load_a: assert property ((load_status_word_instr || accum_to_keys_instr) && !intr_return && !exc.valid
    |=> (keys_to_accum_instr & CRK_KEYS_WR_MASK) == $past(keys_wr_data & CRK_KEYS_WR_MASK))
    else $error("keys load wrong");
  cond_code_a: assert property (alu_res.valid && !key_ld |=> zero_result_flag == ($past(alu_res.result) == 32'h0000_0000)
    && negative_code_flag == $past(alu_res.sign_ext))
    else $error("condition codes wrong");
  crash_save_a: assert property (crash_evt |=> crash_return_save == $past(cur_return_ptr))
    else $error("crash save wrong");
  intr_save_a: assert property (intr_evt |=> interrupt_return_pointer == $past(cur_return_ptr)
    && interrupt_return_keys == $past(keys_to_accum_instr))
    else $error("interrupt save wrong");
  base_zero_a: assert property (base_rd_data[31] == 1'b0 && base_rd_data[28] == 1'b0)
    else $error("base zero bits set");
endmodule : crk_regset_chk

bind crk_regset crk_regset_chk u_chk (
  .ref_clk, .rst, .idx_sel, .idx_data, .idx_used, .keys_to_accum_instr, .keys_wr_data,
  .load_status_word_instr, .accum_to_keys_instr, .intr_return, .exc, .fault_take, .alu_res,
  .zero_result_flag, .negative_code_flag, .pxc_en, .crash_evt, .intr_evt, .cur_return_ptr,
  .crash_return_save, .interrupt_return_pointer, .interrupt_return_keys, .base_rd_data
);

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import crk_pkg::*;
;
  logic ref_clk = 1'b0, rst = 1'b1;
  crk_gr_wr_type gr_wr = '0;
  crk_alu_res_type alu_res = '0;
  crk_exc_type exc = '0;
  logic [2:0] gr_rd_sel = 3'h0, idx_sel = 3'h0;
  logic fr_wr_en = 0, fr_wr_sel = 0, fr_wr_single = 0, fld_addr_wr_en = 0, fld_len_wr_en = 0, fld_wr_sel = 0;
  logic fr_rd_sel = 0, base_wr_en = 0, load_status_word_instr = 0, accum_to_keys_instr = 0;
  logic pxc_en = 0, pxc_in_disp = 0, pxc_save_done = 0, crash_evt = 0, intr_evt = 0, intr_return = 0;
  logic halt_evt = 0, check_trap_evt = 0;
  logic [63:0] fr_wr_data = '0, fr_rd_data;
  logic [31:0] fld_wr_data = '0, base_wr_data = '0, cur_return_ptr = '0, halt_area_addr = '0, check_rma = '0;
  logic [1:0] base_wr_sel = 2'h0, base_rd_sel = 2'h0, base_ring;
  logic [15:0] keys_wr_data = '0, keys_to_accum_instr, interrupt_return_keys, word_number;
  logic [31:0] gr_rd_data, idx_data, field_address_register, field_length_register, base_rd_data;
  logic [31:0] crash_return_save, interrupt_return_pointer, halt_save_area_pointer, check_trap_address;
  logic [11:0] segment_number;
  logic [2:0] addr_mode;
  logic idx_used, negative_code_flag, zero_result_flag, decimal_fault_enable, fault_take;
  int err_total = 0;
  int cmp_count = 0;

  crk_regset u_dut (.ref_clk, .rst, .gr_wr, .gr_rd_sel, .gr_rd_data, .idx_sel, .idx_data, .idx_used,
    .fr_wr_en, .fr_wr_sel, .fr_wr_single, .fr_wr_data, .fld_addr_wr_en, .fld_len_wr_en, .fld_wr_sel,
    .fld_wr_data, .fr_rd_sel, .fr_rd_data, .field_address_register, .field_length_register, .base_wr_en,
    .base_wr_sel, .base_wr_data, .base_rd_sel, .base_rd_data, .base_ring, .segment_number, .word_number,
    .load_status_word_instr, .accum_to_keys_instr, .keys_wr_data, .alu_res, .exc, .pxc_en, .pxc_in_disp,
    .pxc_save_done, .keys_to_accum_instr, .addr_mode, .negative_code_flag, .zero_result_flag,
    .decimal_fault_enable, .fault_take, .crash_evt, .intr_evt, .intr_return, .halt_evt, .check_trap_evt,
    .cur_return_ptr, .halt_area_addr, .check_rma, .crash_return_save, .interrupt_return_pointer,
    .interrupt_return_keys, .halt_save_area_pointer, .check_trap_address);

  always #2 ref_clk = ~ref_clk;

  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic cyc(int n = 1);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic test_done;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic keys_put(logic [15:0] v);
    load_status_word_instr = 1'b1;
    keys_wr_data = v;
    cyc();
    load_status_word_instr = 1'b0;
  endtask : keys_put

  task automatic t_gr;
    for (int i = 0; i < 8; i++) begin
      gr_wr = '{en: 1'b1, sel: i[2:0], data: 32'h1357_0000 + 32'(i)};
      cyc();
    end
    gr_wr.en = 1'b0;
    for (int i = 0; i < 8; i++) begin
      gr_rd_sel = i[2:0];
      idx_sel = i[2:0];
      cyc();
      chk("gr", gr_rd_data, 32'h1357_0000 + 32'(i));
      chk("idx", idx_data, (i == 0) ? 32'h0000_0000 : 32'h1357_0000 + 32'(i));
      chk("idx_used", idx_used, i != 0);
    end
  endtask : t_gr

  task automatic t_fr;
    fr_wr_en = 1'b1;
    fr_wr_data = 64'h0123_4567_89AB_CDEF;
    cyc();
    fr_wr_sel = 1'b1;
    fr_wr_data = 64'hFEDC_BA98_7654_3210;
    cyc();
    fr_wr_en = 1'b0;
    fld_addr_wr_en = 1'b1;
    fld_len_wr_en = 1'b1;
    fld_wr_data = 32'h5555_AAAA;
    cyc();
    fld_addr_wr_en = 1'b0;
    fld_wr_data = 32'h0F0F_1E1E;
    cyc();
    fld_len_wr_en = 1'b0;
    fr_wr_en = 1'b1;
    fr_wr_single = 1'b1;
    fr_wr_data = 64'h1111_2222_3333_4444;
    cyc();
    fr_wr_en = 1'b0;
    cyc();
    chk("fr0", fr_rd_data, 64'h5555_AAAA_0F0F_1E1E);
    chk("far0", field_address_register, 32'h5555_AAAA);
    chk("flr0", field_length_register, 32'h0F0F_1E1E);
    fr_rd_sel = 1'b1;
    cyc();
    chk("fr1", fr_rd_data, 64'h1111_2222_7654_3210);
    chk("flr1", field_length_register, 32'h7654_3210);
  endtask : t_fr

  task automatic t_base;
    base_wr_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      base_wr_sel = i[1:0];
      base_wr_data = 32'hFFFF_FFF0 + 32'(i);
      cyc();
    end
    base_wr_en = 1'b0;
    for (int i = 0; i < 4; i++) begin
      base_rd_sel = i[1:0];
      cyc();
      chk("base", base_rd_data, (32'hFFFF_FFF0 + 32'(i)) & 32'h6FFF_FFFF);
      chk("fields", {base_ring, segment_number, word_number}, {2'h3, 12'hFFF, 16'hFFF0 + 16'(i)});
    end
  endtask : t_base

  task automatic t_keys;
    keys_put(16'hFFFF);
    chk("keys_all", keys_to_accum_instr, 16'hBFE0);
    accum_to_keys_instr = 1'b1;
    keys_wr_data = 16'hB420;
    cyc();
    accum_to_keys_instr = 1'b0;
    chk("keys", keys_to_accum_instr, 16'hB420);
    chk("mode", {addr_mode, decimal_fault_enable}, 4'hB);
    pxc_en = 1'b1;
    pxc_in_disp = 1'b1;
    cyc();
    pxc_en = 1'b0;
    chk("pxc", keys_to_accum_instr, 16'hB422);
    keys_put(16'h0000);
    chk("kept", keys_to_accum_instr, 16'h0002);
    pxc_en = 1'b1;
    pxc_in_disp = 1'b0;
    pxc_save_done = 1'b1;
    cyc();
    pxc_en = 1'b0;
    chk("pxc2", keys_to_accum_instr, 16'h0001);
  endtask : t_keys

  task automatic t_exc;
    logic f;
    for (int k = 0; k < 3; k++) begin
      for (int e = 0; e < 2; e++) begin
        keys_put((e == 1) ? 16'h0320 : 16'h0000);
        exc = '{valid: 1'b1, kind: crk_exc_kind_type'(k)};
        cyc();
        exc.valid = 1'b0;
        f = (k == 0) ? (e == 0) : (e == 1);
        chk("fault", fault_take, f);
        chk("carry", keys_to_accum_instr[15], !f);
      end
    end
  endtask : t_exc

  task automatic t_alu;
    alu_res = '{valid: 1'b1, result: 32'h0000_0000, sign_ext: 1'b1, carry_valid: 1'b1, carry_out: 1'b1};
    cyc();
    chk("cc_zero", {negative_code_flag, zero_result_flag}, 2'b11);
    chk("link", keys_to_accum_instr[CRK_KEY_LINK], 1'b1);
    alu_res.result = 32'h0000_0005;
    alu_res.sign_ext = 1'b0;
    cyc();
    alu_res.valid = 1'b0;
    chk("cc_pos", {negative_code_flag, zero_result_flag}, 2'b00);
  endtask : t_alu

  task automatic t_evt;
    keys_put(16'h9C00);
    cur_return_ptr = 32'h0004_1234;
    halt_area_addr = 32'h0000_0700;
    check_rma = 32'h00AB_CDEF;
    {crash_evt, intr_evt, halt_evt, check_trap_evt} = 4'hF;
    cyc();
    {crash_evt, intr_evt, halt_evt, check_trap_evt} = 4'h0;
    chk("crash", crash_return_save, 32'h0004_1234);
    chk("ipb", interrupt_return_pointer, 32'h0004_1234);
    chk("ikeys", interrupt_return_keys, 16'h9C01);
    chk("halt", halt_save_area_pointer, 32'h0000_0700);
    chk("rma", check_trap_address, 32'h00AB_CDEF);
    keys_put(16'h0000);
    intr_return = 1'b1;
    cyc();
    intr_return = 1'b0;
    chk("restore", keys_to_accum_instr, 16'h9C01);
  endtask : t_evt

  initial begin
    cyc(10);
    rst = 1'b0;
    cyc();
    chk("rst_keys", keys_to_accum_instr, 16'h0000);
    t_gr();
    t_fr();
    t_base();
    t_keys();
    t_exc();
    t_alu();
    t_evt();
    test_done();
  end

  // Normal run is 65 cycles; this cuts a hung run short.
  initial begin
    #40000;
    err_total++;
    test_done();
  end
endmodule : testbench
